/* rtl/pg_wdog.sv */
// power-good combiner, watchdog and output-voltage fault reaction logic
// Notes on behaviour
// - watchdog-include bit ANDs not-expired into output
// - channel include bits AND channel good in
// - unused source-select bits read as zero
// - assert delay counted on shared or internal base
// - assert delay clamped; readback returns written value
// - fast select picks comparator or slow threshold
// - nonzero repeat write or kick restarts watchdog
// - expiry raises alert, drops output, reasserts later
// - zero in either interval disables watchdog
// - first interval after output rises or enable
// - first interval clamped, whole millisecond steps
// - later intervals use clamped repeat setting
// - watchdog uses internal ticks; readback unclamped
// - control, operation or bias toggle clears latch
// - faults set status bits and pull alert
// - clear-faults clears status, not faulted state
// - action 00 keeps channel running
// - action 01 waits deglitch then shuts down
// - actions 10/11 also wait deglitch then shut down
// - retry field zero never restarts
// - nonzero retry restarts up to global limit
// - deglitch field counts persisting fast samples
module pg_wdog
  import pg_wdog_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input pg_wdog_pkg::cmd_req_t cmd_req,
  output pg_wdog_pkg::cmd_rsp_t cmd_rsp,
  input pg_wdog_pkg::supervisor_t sup,
  input wire logic [3:0] control_in,
  input wire logic watchdog_kick_in,
  input wire logic bias_sense_in,
  input wire logic share_clk_in,
  output logic [3:0] channel_enable_out,
  output logic power_good_out,
  output logic alert_low_out
);
  import pg_wdog_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
    logic [6:0] s3;
    logic [6:0] filt;
    logic [7:0] page;
    logic [3:0] op_on;
    logic [3:0][7:0] ov_react;
    logic [3:0][7:0] uv_react;
    logic [6:0][7:0] misc_react;
    logic [15:0] turn_off_delay;
    logic [15:0] restart_interval;
    logic [7:0] restart_limit;
    logic [8:0] ok_src;
    logic [15:0] ok_assert_delay;
    logic [15:0] wd_first;
    logic [15:0] wd_repeat;
    logic [4:0] cfg;
    logic [9:0] tick_cnt;
    logic [6:0] ms_cnt;
    logic [6:0] share_age;
    logic [23:0] ok_cnt;
    logic ok_out;
    wd_state_t wd_st;
    logic [23:0] wd_cnt;
    ch_state_t [3:0] ch_st;
    logic [3:0][23:0] ch_cnt;
    logic [3:0][2:0] ov_dg;
    logic [3:0][2:0] uv_dg;
    logic [3:0][2:0] tries;
    logic [3:0][2:0] ch_retry;
    logic [3:0][7:0] st_vout;
    logic st_wd;
    cmd_rsp_t rsp;
  } state_t;

  state_t q, d;

  // clamp a millisecond value and convert to 10 us units
  function automatic logic [23:0] to_units(input logic [15:0] ms, input logic [15:0] max_ms);
    logic [15:0] c;
    c = (ms > max_ms) ? max_ms : ms;
    return 24'(c) * 24'(TICKS_PER_MS);
  endfunction

  // clamp a millisecond value, kept in milliseconds
  function automatic logic [23:0] to_ms(input logic [15:0] ms, input logic [15:0] max_ms);
    return 24'((ms > max_ms) ? max_ms : ms);
  endfunction

  // page decode: a paged write lands on this channel
  function automatic logic page_hit(input logic [7:0] page, input int ch);
    return (page == PAGE_ALL) || (page == 8'(ch));
  endfunction

  // pin index map inside the synchroniser vectors
  localparam int P_SHARE = 0;
  localparam int P_KICK = 1;
  localparam int P_CTRL = 2;
  localparam int P_BIAS = 6;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic [6:0] nf;
    logic tick10;
    logic tick_ms;
    logic share_fall;
    logic base_tick;
    logic kick;
    logic wr;
    logic rd;
    logic repeat_wr;
    logic wd_en;
    logic wd_expire;
    logic ok_cond;
    logic [3:0] ch_good;
    logic [3:0] on_req;
    logic ov_hit, uv_hit;
    logic [2:0] pidx;
    d = q;
    {nf, tick10, tick_ms, share_fall, base_tick, kick, repeat_wr} = '0;
    {wd_en, ok_cond, ch_good, on_req} = '0;
    d.rsp.valid = 1'b0;
    d.rsp.error = 1'b0;
    wd_expire = 1'b0;
    ov_hit = 1'b0;
    uv_hit = 1'b0;
    pidx = q.page[2:0];
    wr = cmd_req.valid && cmd_req.write;
    rd = cmd_req.valid && !cmd_req.write;

    // three-stage pin sync; a change counts when stages two and three agree
    d.s1 = {bias_sense_in, control_in, watchdog_kick_in, share_clk_in};
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < 7; i++) begin
      nf[i] = (q.s2[i] == q.s3[i]) ? q.s3[i] : q.filt[i];
    end
    d.filt = nf;
    share_fall = q.filt[P_SHARE] && !nf[P_SHARE];
    kick = !q.filt[P_KICK] && nf[P_KICK];

    // internal 10 us and 1 ms ticks, independent of the shared line
    tick10 = (q.tick_cnt == TICK_CYC - 10'h001);
    d.tick_cnt = tick10 ? 10'h000 : q.tick_cnt + 10'h001;
    tick_ms = tick10 && (q.ms_cnt == TICKS_PER_MS - 7'h01);
    if (tick10) begin
      d.ms_cnt = tick_ms ? 7'h00 : q.ms_cnt + 7'h01;
    end

    // shared timebase counts as present while its edges keep coming
    if (share_fall) begin
      d.share_age = 7'h00;
    end else if (tick10 && q.share_age != SHARE_LOSS_TICKS) begin
      d.share_age = q.share_age + 7'h01;
    end
    base_tick = (q.share_age != SHARE_LOSS_TICKS) ? share_fall : tick10;

    // register writes; stored values are never clamped
    if (wr) begin
      unique case (cmd_req.code)
        CMD_PAGE: d.page = cmd_req.wdata[7:0];
        CMD_OPERATION: begin
          for (int i = 0; i < 4; i++) begin
            if (page_hit(q.page, i)) d.op_on[i] = cmd_req.wdata[OP_ON_BIT];
          end
        end
        CMD_CLEAR_FAULTS: begin
          d.st_vout = '0;
          d.st_wd = 1'b0;
        end
        CMD_OV_REACT, CMD_UV_REACT: begin
          for (int i = 0; i < 4; i++) begin
            if (page_hit(q.page, i)) begin
              if (cmd_req.code == CMD_OV_REACT) d.ov_react[i] = cmd_req.wdata[7:0];
              else d.uv_react[i] = cmd_req.wdata[7:0];
            end
          end
        end
        CMD_OC_REACT: d.misc_react[0] = cmd_req.wdata[7:0];
        CMD_UC_REACT: d.misc_react[1] = cmd_req.wdata[7:0];
        CMD_OT_REACT: d.misc_react[2] = cmd_req.wdata[7:0];
        CMD_UT_REACT: d.misc_react[3] = cmd_req.wdata[7:0];
        CMD_VIN_OV_REACT: d.misc_react[4] = cmd_req.wdata[7:0];
        CMD_VIN_UV_REACT: d.misc_react[5] = cmd_req.wdata[7:0];
        CMD_TON_MAX_REACT: d.misc_react[6] = cmd_req.wdata[7:0];
        CMD_TURN_OFF_DELAY: d.turn_off_delay = cmd_req.wdata;
        CMD_SUPERVISOR_CFG: d.cfg = cmd_req.wdata[4:0];
        CMD_OK_SOURCE_SELECT: d.ok_src = cmd_req.wdata[8:0];
        CMD_RESTART_INTERVAL: d.restart_interval = cmd_req.wdata;
        CMD_OK_ASSERT_DELAY: d.ok_assert_delay = cmd_req.wdata;
        CMD_WDOG_FIRST: d.wd_first = cmd_req.wdata;
        CMD_WDOG_REPEAT: begin
          d.wd_repeat = cmd_req.wdata;
          repeat_wr = (cmd_req.wdata != 16'h0000);
        end
        CMD_RESTART_LIMIT: d.restart_limit = cmd_req.wdata[7:0] & LIMIT_MASK;
        default: d.rsp.error = 1'b1;
      endcase
      d.rsp.valid = 1'b1;
    end

    // register reads; unknown or write-only codes answer with an error
    if (rd) begin
      d.rsp.valid = 1'b1;
      d.rsp.rdata = 16'h0000;
      unique case (cmd_req.code)
        CMD_PAGE: d.rsp.rdata = {8'h00, q.page};
        CMD_OPERATION: d.rsp.rdata = {8'h00, q.op_on[pidx[1:0]], 7'h00};
        CMD_OV_REACT: d.rsp.rdata = {8'h00, q.ov_react[pidx[1:0]]};
        CMD_UV_REACT: d.rsp.rdata = {8'h00, q.uv_react[pidx[1:0]]};
        CMD_OC_REACT: d.rsp.rdata = {8'h00, q.misc_react[0]};
        CMD_UC_REACT: d.rsp.rdata = {8'h00, q.misc_react[1]};
        CMD_OT_REACT: d.rsp.rdata = {8'h00, q.misc_react[2]};
        CMD_UT_REACT: d.rsp.rdata = {8'h00, q.misc_react[3]};
        CMD_VIN_OV_REACT: d.rsp.rdata = {8'h00, q.misc_react[4]};
        CMD_VIN_UV_REACT: d.rsp.rdata = {8'h00, q.misc_react[5]};
        CMD_TON_MAX_REACT: d.rsp.rdata = {8'h00, q.misc_react[6]};
        CMD_TURN_OFF_DELAY: d.rsp.rdata = q.turn_off_delay;
        CMD_STATUS_BYTE, CMD_STATUS_WORD: begin
          d.rsp.rdata[7:0] = (((q.st_vout[0] | q.st_vout[1] | q.st_vout[2] | q.st_vout[3])
                              & VOUT_OV_BIT) != 8'h00) ? SBYTE_VOUT_OV : 8'h00;
          d.rsp.rdata[7:0] = d.rsp.rdata[7:0] | (q.st_wd ? SBYTE_OTHER : 8'h00);
          if (cmd_req.code == CMD_STATUS_WORD && |q.st_vout) begin
            d.rsp.rdata[15:8] = SWORD_VOUT;
          end
        end
        CMD_STATUS_VOUT: d.rsp.rdata = {8'h00, q.st_vout[pidx[1:0]]};
        CMD_SUPERVISOR_CFG: d.rsp.rdata = {11'h000, q.cfg};
        CMD_STATUS_SUPERVISOR: d.rsp.rdata = {15'h0000, q.st_wd};
        CMD_OK_SOURCE_SELECT: d.rsp.rdata = {7'h00, q.ok_src} & OK_SRC_MASK;
        CMD_RESTART_INTERVAL: d.rsp.rdata = q.restart_interval;
        CMD_OK_ASSERT_DELAY: d.rsp.rdata = q.ok_assert_delay;
        CMD_WDOG_FIRST: d.rsp.rdata = q.wd_first;
        CMD_WDOG_REPEAT: d.rsp.rdata = q.wd_repeat;
        CMD_RESTART_LIMIT: d.rsp.rdata = {8'h00, q.restart_limit};
        default: d.rsp.error = 1'b1;
      endcase
    end

    // watchdog: both intervals run on the internal ticks only
    wd_en = (q.wd_first != 16'h0000) && (q.wd_repeat != 16'h0000);
    unique case (q.wd_st)
      WD_OFF: begin
        d.wd_cnt = '0;
        if (wd_en) d.wd_st = q.ok_src[OK_SRC_WDOG_BIT] ? WD_WAIT_OK : WD_FIRST;
      end
      WD_WAIT_OK: begin
        d.wd_cnt = '0;
        if (q.ok_out) d.wd_st = WD_FIRST;
      end
      WD_FIRST: begin
        if (q.wd_cnt >= to_ms(q.wd_first, WDOG_FIRST_MAX_MS)) begin
          wd_expire = 1'b1;
        end else if (tick_ms) begin
          d.wd_cnt = q.wd_cnt + 24'h000001;
        end
      end
      WD_REPEAT: begin
        if (q.wd_cnt >= to_units(q.wd_repeat, WDOG_REPEAT_MAX_MS)) begin
          wd_expire = 1'b1;
        end else if (tick10) begin
          d.wd_cnt = q.wd_cnt + 24'h000001;
        end
      end
    endcase
    // a kick restarts the count; later periods use the repeat setting
    if ((q.wd_st == WD_FIRST || q.wd_st == WD_REPEAT) && (kick || repeat_wr)) begin
      d.wd_st = WD_REPEAT;
      d.wd_cnt = '0;
      wd_expire = 1'b0;
    end
    if (wd_expire) begin
      d.st_wd = 1'b1;
      d.wd_cnt = '0;
      d.wd_st = q.ok_src[OK_SRC_WDOG_BIT] ? WD_WAIT_OK : WD_FIRST;
    end
    if (!wd_en) d.wd_st = WD_OFF;

    // channel good source: fast comparator or slow polled threshold
    for (int i = 0; i < 4; i++) begin
      ch_good[i] = q.cfg[0] ? (q.ch_st[i] == CH_ON) && !sup.under_fast[i]
                            : sup.ok_slow[i];
    end

    // combined condition: included channels and not-expired watchdog
    ok_cond = &(~q.ok_src[3:0] | ch_good)
              && !(q.ok_src[OK_SRC_WDOG_BIT] && wd_expire);
    if (!ok_cond) begin
      d.ok_out = 1'b0;
      d.ok_cnt = '0;
    end else if (!q.ok_out) begin
      if (q.ok_cnt >= to_units(q.ok_assert_delay, OK_DELAY_MAX_MS)) begin
        d.ok_out = 1'b1;
      end else if (base_tick) begin
        d.ok_cnt = q.ok_cnt + 24'h000001;
      end
    end

    // per-channel deglitch, fault reaction and restart handling
    for (int i = 0; i < 4; i++) begin
      on_req[i] = nf[P_CTRL + i] && q.op_on[i] && nf[P_BIAS];
      // deglitch: fault must persist the field's count of samples
      if (!sup.over_fast[i]) d.ov_dg[i] = 3'h0;
      else if (sup.sample_tick && q.ov_dg[i] != q.ov_react[i][2:0]) d.ov_dg[i] = q.ov_dg[i] + 3'h1;
      if (!sup.under_fast[i]) d.uv_dg[i] = 3'h0;
      else if (sup.sample_tick && q.uv_dg[i] != q.uv_react[i][2:0]) d.uv_dg[i] = q.uv_dg[i] + 3'h1;
      ov_hit = sup.over_fast[i] && (q.ov_dg[i] == q.ov_react[i][2:0]);
      uv_hit = sup.under_fast[i] && (q.uv_dg[i] == q.uv_react[i][2:0]);
      // status set wins over a clear-faults in the same cycle
      if (ov_hit && q.ch_st[i] == CH_ON) d.st_vout[i] = d.st_vout[i] | VOUT_OV_BIT;
      if (uv_hit && q.ch_st[i] == CH_ON) d.st_vout[i] = d.st_vout[i] | VOUT_UV_BIT;
      // actions 00 ignore; 01, 10 and 11 all shut down after deglitch
      ov_hit = ov_hit && (q.ov_react[i][7:6] != 2'b00);
      uv_hit = uv_hit && (q.uv_react[i][7:6] != 2'b00);
      unique case (q.ch_st[i])
        CH_OFF: begin
          if (on_req[i]) d.ch_st[i] = CH_ON;
        end
        CH_ON: begin
          if (ov_hit || uv_hit) begin
            d.ch_retry[i] = ov_hit ? q.ov_react[i][5:3] : q.uv_react[i][5:3];
            d.ch_st[i] = q.cfg[1 + i] ? CH_SEQ_OFF : CH_FAULTED;
            d.ch_cnt[i] = '0;
          end
        end
        CH_SEQ_OFF: begin
          if (q.ch_cnt[i] >= to_units(q.turn_off_delay, TURN_OFF_MAX_MS)) begin
            d.ch_st[i] = CH_FAULTED;
            d.ch_cnt[i] = '0;
          end else if (base_tick) begin
            d.ch_cnt[i] = q.ch_cnt[i] + 24'h000001;
          end
        end
        CH_FAULTED: begin
          // zero retry field or exhausted limit holds the channel off
          if (q.ch_retry[i] != 3'h0 && (q.restart_limit[2:0] == LIMIT_INFINITE
              || q.tries[i] < q.restart_limit[2:0])) begin
            if (q.ch_cnt[i] >= to_units(q.restart_interval, RESTART_MAX_MS)) begin
              d.ch_st[i] = CH_ON;
              d.ch_cnt[i] = '0;
              if (q.restart_limit[2:0] != LIMIT_INFINITE) d.tries[i] = q.tries[i] + 3'h1;
            end else if (base_tick) begin
              d.ch_cnt[i] = q.ch_cnt[i] + 24'h000001;
            end
          end
        end
      endcase
      // commanded off or bias lost: latch and attempt count clear
      if (!on_req[i]) begin
        d.ch_st[i] = CH_OFF;
        d.ch_cnt[i] = '0;
        d.tries[i] = 3'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q <= '0;
      q.ov_react <= {4{RST_OV_REACT}};
      q.uv_react <= {4{RST_UV_REACT}};
      q.misc_react <= {RST_TON_MAX_REACT, RST_VIN_UV_REACT, RST_VIN_OV_REACT, RST_UT_REACT,
                       RST_OT_REACT, RST_UC_REACT, RST_OC_REACT};
      q.turn_off_delay <= RST_TURN_OFF_DELAY;
      q.restart_interval <= RST_RESTART_INTERVAL;
      q.restart_limit <= RST_RESTART_LIMIT;
      q.ok_assert_delay <= RST_OK_ASSERT_DELAY;
      q.wd_first <= RST_WDOG;
      q.wd_repeat <= RST_WDOG;
      q.op_on <= 4'hf;
      q.share_age <= SHARE_LOSS_TICKS;
      q.wd_st <= WD_OFF;
      q.ch_st <= {4{CH_OFF}};
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // alert follows the sticky status; cleared only by clear-faults
  assign alert_low_out = !(|q.st_vout || q.st_wd);
  assign power_good_out = q.ok_out;
  assign cmd_rsp = q.rsp;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      channel_enable_out[i] = (q.ch_st[i] == CH_ON) || (q.ch_st[i] == CH_SEQ_OFF);
    end
  end
endmodule

/* rtl/pg_wdog_pkg.sv */
// package: command codes, field layouts, timing constants and state types
package pg_wdog_pkg;
  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_OV_REACT = 8'h41;
  localparam logic [7:0] CMD_UV_REACT = 8'h45;
  localparam logic [7:0] CMD_OC_REACT = 8'h47;
  localparam logic [7:0] CMD_UC_REACT = 8'h4c;
  localparam logic [7:0] CMD_OT_REACT = 8'h50;
  localparam logic [7:0] CMD_UT_REACT = 8'h54;
  localparam logic [7:0] CMD_VIN_OV_REACT = 8'h56;
  localparam logic [7:0] CMD_VIN_UV_REACT = 8'h5a;
  localparam logic [7:0] CMD_TON_MAX_REACT = 8'h63;
  localparam logic [7:0] CMD_TURN_OFF_DELAY = 8'h64;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_STATUS_VOUT = 8'h7a;
  localparam logic [7:0] CMD_SUPERVISOR_CFG = 8'hd1;
  localparam logic [7:0] CMD_STATUS_SUPERVISOR = 8'hd2;
  localparam logic [7:0] CMD_OK_SOURCE_SELECT = 8'hd4;
  localparam logic [7:0] CMD_RESTART_INTERVAL = 8'hdb;
  localparam logic [7:0] CMD_OK_ASSERT_DELAY = 8'he1;
  localparam logic [7:0] CMD_WDOG_FIRST = 8'he2;
  localparam logic [7:0] CMD_WDOG_REPEAT = 8'he3;
  localparam logic [7:0] CMD_RESTART_LIMIT = 8'hf7;
  localparam logic [7:0] PAGE_ALL = 8'hff;

  // ---------------------------------------------------------------
  // reset values and field layouts
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_OV_REACT = 8'h80;
  localparam logic [7:0] RST_UV_REACT = 8'h7f;
  localparam logic [7:0] RST_OC_REACT = 8'h00;
  localparam logic [7:0] RST_UC_REACT = 8'h00;
  localparam logic [7:0] RST_OT_REACT = 8'hb8;
  localparam logic [7:0] RST_UT_REACT = 8'hb8;
  localparam logic [7:0] RST_VIN_OV_REACT = 8'h80;
  localparam logic [7:0] RST_VIN_UV_REACT = 8'h00;
  localparam logic [7:0] RST_TON_MAX_REACT = 8'hb8;
  localparam logic [15:0] RST_RESTART_INTERVAL = 16'hf320;
  localparam logic [7:0] RST_RESTART_LIMIT = 8'h07;
  localparam logic [15:0] RST_OK_ASSERT_DELAY = 16'h0064;
  localparam logic [15:0] RST_WDOG = 16'h0000;
  localparam logic [15:0] RST_TURN_OFF_DELAY = 16'h0001;
  localparam logic [15:0] OK_SRC_MASK = 16'h010f;
  localparam int OK_SRC_WDOG_BIT = 8;
  localparam int OP_ON_BIT = 7;
  localparam logic [7:0] LIMIT_MASK = 8'h07;
  localparam logic [2:0] LIMIT_INFINITE = 3'h7;
  localparam logic [7:0] VOUT_OV_BIT = 8'h80;
  localparam logic [7:0] VOUT_UV_BIT = 8'h10;
  localparam logic [7:0] SBYTE_VOUT_OV = 8'h20;
  localparam logic [7:0] SBYTE_OTHER = 8'h01;
  localparam logic [7:0] SWORD_VOUT = 8'h80;

  // ---------------------------------------------------------------
  // timing: values are whole milliseconds, counted in 10 us units except the first watchdog interval (1 ms steps)
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 10000;
  localparam logic [9:0] TICK_CYC = 10'(TICK_NS / CLK_PERIOD_NS);
  localparam logic [6:0] TICKS_PER_MS = 7'h64;
  localparam logic [6:0] SHARE_LOSS_TICKS = 7'h64;
  localparam logic [15:0] OK_DELAY_MAX_MS = 16'h332c;
  localparam logic [15:0] WDOG_FIRST_MAX_MS = 16'hfde8;
  localparam logic [15:0] WDOG_REPEAT_MAX_MS = 16'h028f;
  localparam logic [15:0] TURN_OFF_MAX_MS = 16'h028f;
  localparam logic [15:0] RESTART_MAX_MS = 16'h332c;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {WD_OFF, WD_WAIT_OK, WD_FIRST, WD_REPEAT} wd_state_t;
  typedef enum logic [1:0] {CH_OFF, CH_ON, CH_SEQ_OFF, CH_FAULTED} ch_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } cmd_req_t;

  typedef struct packed {
    logic valid;
    logic error;
    logic [15:0] rdata;
  } cmd_rsp_t;

  typedef struct packed {
    logic [3:0] over_fast;
    logic [3:0] under_fast;
    logic [3:0] ok_slow;
    logic sample_tick;
  } supervisor_t;
endpackage

/* bench/pg_wdog_sva.sv */
// checker: port-level properties of the power-good and fault block
module pg_wdog_sva
  import pg_wdog_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input pg_wdog_pkg::cmd_req_t cmd_req,
  input pg_wdog_pkg::cmd_rsp_t cmd_rsp,
  input pg_wdog_pkg::supervisor_t sup,
  input wire logic [3:0] channel_enable_out,
  input wire logic power_good_out,
  input wire logic alert_low_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] sel_q, dly_q, wf_q, wr_q;
  logic fast_q, cfg_q, rd_c, wr_c, flt, wd_on, ok_all;
  logic [3:0] good;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // shadow settings
  // ----------------------------------------------------------------
  assign wr_c = cmd_req.valid && cmd_req.write;
  assign rd_c = cmd_req.valid && !cmd_req.write;
  assign good = fast_q ? ~sup.under_fast : sup.ok_slow;
  assign ok_all = &(good | ~sel_q[3:0]);
  assign flt = |((sup.over_fast | sup.under_fast) & channel_enable_out);
  assign wd_on = (wf_q != 16'h0000) && (wr_q != 16'h0000);
  // the select bit is unknown until written, so cfg_q gates its users
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sel_q <= 16'h0000;
      dly_q <= RST_OK_ASSERT_DELAY;
      wf_q <= RST_WDOG;
      wr_q <= RST_WDOG;
      cfg_q <= 1'b0;
    end else if (wr_c) begin
      if (cmd_req.code == CMD_OK_SOURCE_SELECT) sel_q <= cmd_req.wdata;
      if (cmd_req.code == CMD_OK_ASSERT_DELAY) dly_q <= cmd_req.wdata;
      if (cmd_req.code == CMD_WDOG_FIRST) wf_q <= cmd_req.wdata;
      if (cmd_req.code == CMD_WDOG_REPEAT) wr_q <= cmd_req.wdata;
      if (cmd_req.code == CMD_SUPERVISOR_CFG) cfg_q <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (wr_c && cmd_req.code == CMD_SUPERVISOR_CFG) fast_q <= cmd_req.wdata[0];
  end
  rsp_timing_a: assert property (cmd_rsp.valid == $past(cmd_req.valid))
    else $error("answer not one cycle after command");
  sel_mask_a: assert property (rd_c && cmd_req.code == CMD_OK_SOURCE_SELECT
    |=> cmd_rsp.rdata == (sel_q & OK_SRC_MASK)) else $error("select readback wrong");
  dly_readback_a: assert property (rd_c && cmd_req.code == CMD_OK_ASSERT_DELAY
    |=> cmd_rsp.rdata == dly_q) else $error("delay readback wrong");
  first_readback_a: assert property (rd_c && cmd_req.code == CMD_WDOG_FIRST
    |=> cmd_rsp.rdata == wf_q) else $error("first interval readback wrong");
  pg_rise_a: assert property (cfg_q && $rose(power_good_out)
    |-> $past(ok_all) || $past(ok_all, 2)) else $error("power good rose early");
  pg_drop_a: assert property (cfg_q && power_good_out && !ok_all
    |=> !power_good_out) else $error("power good held too long");
  pg_fall_a: assert property (cfg_q && $fell(power_good_out)
    |-> !$past(ok_all) || ($past(wd_on) && $past(sel_q[8]))) else $error("power good fell");
  clear_alert_a: assert property (wr_c && cmd_req.code == CMD_CLEAR_FAULTS
    && !flt && !wd_on |=> alert_low_out) else $error("alert kept after clear");
  alert_cause_a: assert property ($fell(alert_low_out)
    |-> wd_on || $past(flt) || $past(flt, 2)) else $error("alert without cause");
endmodule

bind pg_wdog pg_wdog_sva chk_u (.clk_sys(clk_sys), .srst(srst), .cmd_req(cmd_req),
  .cmd_rsp(cmd_rsp), .sup(sup), .channel_enable_out(channel_enable_out),
  .power_good_out(power_good_out), .alert_low_out(alert_low_out));

/* bench/supply_model.sv */
// partner model: four supervised converters seen through fast and slow monitors
module supply_model
  import pg_wdog_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [3:0] en,
  input wire logic [3:0] ov_inj,
  input wire logic [3:0] uv_inj,
  output pg_wdog_pkg::supervisor_t sup
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] tick_q = 3'h0;
  // scanning supervisor visits each channel once every eight cycles
  always @(posedge clk_sys) tick_q <= tick_q + 3'h1;
  // a disabled converter collapses: under, not good, never over
  always_comb begin
    sup.over_fast = ov_inj & en;
    sup.under_fast = uv_inj | ~en;
    sup.ok_slow = en & ~uv_inj;
    sup.sample_tick = (tick_q == 3'h7);
  end
endmodule

/* bench/tb_top.sv */
// testbench: register port, power-good combining and fault reaction
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pg_wdog_pkg::*;
  logic clk_sys = 1'b0, srst = 1'b1;
  logic kick = 1'b0, share = 1'b1;
  logic pg, alert_low;
  logic [3:0] ctl = 4'hf, ov = 4'h0, uv = 4'h0, en;
  cmd_req_t req = '0;
  cmd_rsp_t rsp;
  supervisor_t sup;
  logic [17:0] q[$], e;
  logic [31:0] seed = 32'h1e;
  int mismatches = 0, n_checks = 0, cyc = 0;

  pg_wdog dut_u (.clk_sys(clk_sys), .srst(srst), .cmd_req(req), .cmd_rsp(rsp), .sup(sup),
    .control_in(ctl), .watchdog_kick_in(kick), .bias_sense_in(1'b1), .share_clk_in(share),
    .channel_enable_out(en), .power_good_out(pg), .alert_low_out(alert_low));
  supply_model sm_u (.clk_sys(clk_sys), .en(en), .ov_inj(ov), .uv_inj(uv), .sup(sup));

  initial forever #5 clk_sys = ~clk_sys;
  // shared timebase: one falling edge every 10 us
  initial forever #5000 share = ~share;
  // hang guard, far above the test length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic chk(string n, logic [15:0] s, logic [15:0] x);
    n_checks++;
    if (s !== x) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, x, s);
    end
  endtask
  // expectation word: [17] compare data, [16] error, [15:0] data
  task automatic cmd(logic w, logic [7:0] c, logic [15:0] d, logic [17:0] x);
    @(negedge clk_sys);
    req = '{1'b1, w, c, d};
    q.push_back(x);
    @(negedge clk_sys);
    req.valid = 1'b0;
  endtask
  task automatic wr(logic [7:0] c, logic [15:0] d);
    cmd(1'b1, c, d, 18'h0);
  endtask
  task automatic rd(logic [7:0] c, logic [15:0] x);
    cmd(1'b0, c, 16'h0, {2'b10, x});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // answers are taken off the queue oldest first
  always @(negedge clk_sys) begin
    if (rsp.valid === 1'b1) begin
      e = q.pop_front();
      chk("error", {15'h0, rsp.error}, {15'h0, e[16]});
      if (e[17]) chk("rdata", rsp.rdata, e[15:0]);
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    static logic [7:0] rc[11] = '{CMD_OV_REACT, CMD_UV_REACT, CMD_OC_REACT, CMD_UC_REACT,
      CMD_OT_REACT, CMD_UT_REACT, CMD_VIN_OV_REACT, CMD_VIN_UV_REACT, CMD_TON_MAX_REACT,
      CMD_RESTART_INTERVAL, CMD_RESTART_LIMIT};
    static logic [15:0] rv[11] = '{16'h80, 16'h7f, 16'h00, 16'h00, 16'hb8, 16'hb8, 16'h80,
      16'h00, 16'hb8, 16'hf320, 16'h07};
    logic [15:0] d;
    repeat (20) @(negedge clk_sys);
    srst = 1'b0;
    foreach (rc[i]) rd(rc[i], rv[i]);
    cmd(1'b0, 8'h02, 16'h0, 18'h10000);
    $display("reset values done");
    repeat (4) begin
      d = xs();
      wr(CMD_OK_SOURCE_SELECT, d);
      rd(CMD_OK_SOURCE_SELECT, d & OK_SRC_MASK);
      wr(CMD_OK_ASSERT_DELAY, d);
      rd(CMD_OK_ASSERT_DELAY, d);
      wr(CMD_WDOG_FIRST, d);
      rd(CMD_WDOG_FIRST, d);
    end
    wr(CMD_WDOG_FIRST, 16'h0000);
    $display("readback done");
    wr(CMD_SUPERVISOR_CFG, 16'h0000);
    wr(CMD_PAGE, {8'h00, PAGE_ALL});
    wr(CMD_UV_REACT, 16'h0000);
    wr(CMD_OK_ASSERT_DELAY, 16'h0000);
    wr(CMD_OK_SOURCE_SELECT, 16'h000f);
    repeat (30) @(negedge clk_sys);
    chk("pg", pg, 1);
    uv[2] = 1'b1;
    repeat (8) @(negedge clk_sys);
    chk("pg", pg, 0);
    chk("en", en, 4'hf);
    chk("alert", alert_low, 0);
    wr(CMD_PAGE, 16'h0002);
    rd(CMD_STATUS_VOUT, {8'h00, VOUT_UV_BIT});
    uv[2] = 1'b0;
    wr(CMD_OK_SOURCE_SELECT, 16'h000b);
    uv[2] = 1'b1;
    repeat (8) @(negedge clk_sys);
    chk("pg", pg, 1);
    uv[2] = 1'b0;
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    repeat (2) @(negedge clk_sys);
    chk("alert", alert_low, 1);
    $display("power good done");
    ov[1] = 1'b1;
    repeat (20) @(negedge clk_sys);
    ov[1] = 1'b0;
    chk("en1", en[1], 0);
    chk("alert", alert_low, 0);
    rd(CMD_STATUS_WORD, {SWORD_VOUT, SBYTE_VOUT_OV});
    repeat (300) @(negedge clk_sys);
    chk("en1", en[1], 0);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    repeat (2) @(negedge clk_sys);
    chk("alert", alert_low, 1);
    chk("en1", en[1], 0);
    ctl[1] = 1'b0;
    repeat (10) @(negedge clk_sys);
    ctl[1] = 1'b1;
    for (int i = 0; i < 50 && en[1] !== 1'b1; i++) @(negedge clk_sys);
    chk("en1", en[1], 1);
    $display("overvoltage done");
    wr(CMD_OK_SOURCE_SELECT, 16'h0100);
    wr(CMD_WDOG_REPEAT, 16'h0001);
    repeat (4) begin
      kick = ~kick;
      repeat (40) @(negedge clk_sys);
    end
    chk("pg", pg, 1);
    $display("watchdog done");
    end_of_test();
  end
endmodule
